// file: pkg/ucp_fifo_if.sv
// Interface: push and pop handshake between the command port and its FIFO
`timescale 1ns/100ps
interface ucp_fifo_if #(parameter int unsigned W = 22);
  logic         push_valid;
  logic [W-1:0] push_data;
  logic         push_ready;
  logic         pop_valid;
  logic [W-1:0] pop_data;
  logic         pop_ready;
  logic         flush;
  modport src (output push_valid, push_data, pop_ready, flush,
               input  push_ready, pop_valid, pop_data);
  modport mem (input  push_valid, push_data, pop_ready, flush,
               output push_ready, pop_valid, pop_data);
endinterface

// file: pkg/ucp_pkg.sv
// Package: command codes, field positions and reset values of the command port
package ucp_pkg;
  typedef enum logic [1:0] {
    UCP_IDLE  = 2'b00,
    UCP_WDATA = 2'b01,
    UCP_RDATA = 2'b10
  } ucp_state_t;

  // Command groups by upper nibble; lower nibble selects the endpoint slot
  localparam logic [3:0]  GRP_FILL     = 4'h0;
  localparam logic [3:0]  GRP_DRAIN    = 4'h1;
  localparam logic [3:0]  GRP_CFG_WR   = 4'h2;
  localparam logic [3:0]  GRP_CFG_RD   = 4'h3;
  localparam logic [3:0]  GRP_STALL    = 4'h4;
  localparam logic [3:0]  GRP_STAT     = 4'h5;
  localparam logic [3:0]  GRP_VALID    = 4'h6;
  localparam logic [3:0]  GRP_CLEAR    = 4'h7;
  localparam logic [3:0]  GRP_UNSTALL  = 4'h8;
  localparam logic [3:0]  GRP_IMAGE    = 4'hd;
  localparam logic [3:0]  EP_CTRL_OUT  = 4'h0;
  localparam logic [3:0]  EP_CTRL_IN   = 4'h1;

  localparam logic [7:0]  CMD_ERR_OUT  = 8'ha0;
  localparam logic [7:0]  CMD_ERR_IN   = 8'ha1;
  localparam logic [7:0]  CMD_ADDR_WR  = 8'hb6;
  localparam logic [7:0]  CMD_ADDR_RD  = 8'hb7;
  localparam logic [7:0]  CMD_MODE_WR  = 8'hb8;
  localparam logic [7:0]  CMD_MODE_RD  = 8'hb9;
  localparam logic [7:0]  CMD_HW_WR    = 8'hba;
  localparam logic [7:0]  CMD_HW_RD    = 8'hbb;
  localparam logic [7:0]  CMD_IRQ_WR   = 8'hc2;
  localparam logic [7:0]  CMD_IRQ_RD   = 8'hc3;
  localparam logic [7:0]  CMD_DMAC_WR  = 8'hf0;
  localparam logic [7:0]  CMD_DMAC_RD  = 8'hf1;
  localparam logic [7:0]  CMD_DMAN_WR  = 8'hf2;
  localparam logic [7:0]  CMD_DMAN_RD  = 8'hf3;
  localparam logic [7:0]  CMD_SETUP_ACK = 8'hf4;
  localparam logic [7:0]  CMD_DEV_RESET = 8'hf6;

  localparam logic [7:0]  RST_ADDR     = 8'h00;
  localparam logic [7:0]  RST_MODE     = 8'h00;
  localparam logic [15:0] RST_HW       = 16'h0000;
  localparam logic [31:0] RST_IRQ      = 32'h0000_0000;
  localparam logic [15:0] RST_DMAC     = 16'h0000;
  localparam logic [15:0] RST_DMAN     = 16'h0000;
  localparam logic [7:0]  RST_CFG      = 8'h00;

  localparam int unsigned CFG_ISO_BIT  = 4;
  localparam logic [15:0] MAX_LEN_ISO  = 16'h03ff;
  localparam logic [15:0] MAX_LEN_STD  = 16'h0040;

  localparam int unsigned IDX_W        = 10;
  localparam logic [9:0]  IDX_MAX      = 10'h3ff;

  // Transmit word: {last, odd, endpoint, data}
  localparam int unsigned TXF_W        = 22;
  localparam int unsigned TXF_LAST     = 21;
  localparam int unsigned TXF_ODD      = 20;
  localparam int unsigned TXF_EP_LO    = 16;
  localparam int unsigned TXF_DEPTH    = 8;
endpackage

// file: tb/test_usb_device_command_port.sv
// Self-checking bench for the command port
`timescale 1ns/100ps
module test_usb_device_command_port;
  logic        core_clk = 1'b0, rst_n = 1'b0, tx_ready = 1'b0;
  logic        bus_cs_n, bus_a0, bus_rd_n, bus_wr_n, bus_data_oe, rx_take, tx_valid, tx_last;
  logic        tx_odd, ep_validate, ep_clear, status_ack, setup_ack, fill_overflow;
  logic [3:0]  tx_ep, evt_ep, s;
  logic [7:0]  usb_address_reg, operating_mode_reg, err_code_out, err_code_in;
  logic [15:0] bus_data_in, bus_data_out, tx_data, stall_mask, hardware_setup_reg, q, r, d;
  logic [15:0] ep_full, rx_len, rx_word, dma_setup_reg, dma_byte_count_reg;
  logic [31:0] irq_mask_reg;
  logic [15:0] wv[5];
  logic [21:0] txq[$];
  logic [7:0]  rw[5] = '{8'hb6, 8'hb8, 8'hba, 8'hf0, 8'hf2};
  logic [7:0]  nc[7] = '{8'h61, 8'h72, 8'hf4, 8'h60, 8'h71, 8'h00, 8'h11};
  int          fails = 0, compares = 0, pulses = 0, takes = 0, acks = 0;

  ucp_command_port i_ucp_command_port (.*);
  ucp_host host (.*);

  initial forever #2.5 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Far side stalls at random; model queue holds expected words
  always @(posedge core_clk) begin
    tx_ready <= 1'($urandom);
    pulses <= pulses + int'(ep_validate) + int'(ep_clear) + int'(setup_ack);
    takes <= takes + int'(rx_take);
    acks <= acks + int'(status_ack);
    if (tx_valid && tx_ready) chk({tx_last, tx_odd, tx_ep, tx_data}, txq.pop_front());
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    close_out();
  end

  initial begin
    void'($urandom(62569));
    ep_full = 16'($urandom);
    rx_len = 16'(1 + $urandom % 64);
    rx_word = 16'($urandom);
    err_code_out = 8'($urandom);
    err_code_in = 8'($urandom);
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk(irq_mask_reg, 32'h0);
    foreach (rw[i]) begin
      d = 16'($urandom);
      wv[i] = d;
      host.wc(rw[i], d);
      host.rc(rw[i] + 8'h01, q);
      chk(q, i < 2 ? {8'h00, d[7:0]} : d);
    end
    chk({usb_address_reg, operating_mode_reg}, {wv[0][7:0], wv[1][7:0]});
    chk({hardware_setup_reg, dma_setup_reg}, {wv[2], wv[3]});
    chk(dma_byte_count_reg, wv[4]);
    q = 16'($urandom);
    r = 16'($urandom);
    host.wc(8'hc2, q);
    host.acc(1'b0, 1'b0, r, d);
    chk(irq_mask_reg, {r, q});
    host.rc(8'hc3, d);
    chk(d, q);
    host.rd(d);
    chk(d, r);
    $display("test registers done");
    s = 4'($urandom);
    d = 16'($urandom);
    host.wc({4'h2, s}, d);
    host.rc({4'h3, s}, q);
    chk(q, {8'h00, d[7:0]});
    host.cmd({4'h4, s});
    chk(stall_mask[s], 1'b1);
    host.rc({4'h5, s}, q);
    chk(q, {14'h0, 1'b1, ep_full[s]});
    chk(acks, 1);
    chk(evt_ep, s);
    host.rc({4'hd, s}, q);
    chk(q, {14'h0, 1'b1, ep_full[s]});
    chk(acks, 1);
    host.cmd({4'h8, s});
    chk(stall_mask, 16'h0);
    host.rc(8'ha0, q);
    chk(q, {8'h00, err_code_out});
    host.rc(8'ha1, q);
    chk(q, {8'h00, err_code_in});
    foreach (nc[i]) host.cmd(nc[i]);
    chk(pulses, 3);
    $display("test endpoint done");
    host.wc(8'h01, 16'h0005);
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom);
      if (i < 3) txq.push_back({i == 2, 1'b1, 4'h1, d});
      host.acc(1'b0, 1'b0, d, q); // Fourth word lies past the count
    end
    repeat (40) @(posedge core_clk);
    chk(txq.size(), 0);
    chk(fill_overflow, 1'b0);
    host.rc(8'h10, q);
    chk(q, rx_len);
    for (int i = 1; i <= (rx_len + 1) / 2; i++) begin
      fork
        host.rd(q);
        begin
          repeat (6) @(posedge core_clk);
          chk(bus_data_oe, 1'b1);
        end
      join
      if (i == (rx_len + 1) / 2 && rx_len[0]) chk(q[7:0], rx_word[7:0]);
      else chk(q, rx_word);
    end
    host.rd(q);
    chk({q, 15'h0, bus_data_oe}, 32'h0);
    chk(takes, (rx_len + 1) / 2);
    host.cmd(8'h45);
    host.cmd(8'hf6);
    chk({usb_address_reg, stall_mask}, 24'h0);
    $display("test flow done");
    close_out();
  end
endmodule

// file: tb/ucp_host.sv
// Host processor model driving the command port pins
`timescale 1ns/100ps
module ucp_host (
  input  wire logic        core_clk,
  output logic             bus_cs_n = 1'b1,
  output logic             bus_a0 = 1'b0,
  output logic             bus_rd_n = 1'b1,
  output logic             bus_wr_n = 1'b1,
  output logic      [15:0] bus_data_in = 16'h0000,
  input  wire logic [15:0] bus_data_out
);
  // Whole words only, long strobes
  task automatic acc(input logic a, input logic r, input logic [15:0] d, output logic [15:0] q);
    @(posedge core_clk);
    bus_cs_n <= 1'b0;
    bus_a0 <= a;
    bus_rd_n <= !r;
    bus_wr_n <= r;
    bus_data_in <= d;
    repeat (8) @(posedge core_clk);
    q = bus_data_out;
    bus_rd_n <= 1'b1;
    bus_wr_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    bus_cs_n <= 1'b1;
    bus_data_in <= ~d; // Released bus must not look stale
    repeat (6) @(posedge core_clk);
  endtask
  // Refused codes are sent only on purpose
  task automatic cmd(input logic [7:0] c);
    logic [15:0] q;
    acc(1'b1, 1'b0, {8'($urandom), c}, q); // Upper byte noise
  endtask
  // Low word first for wide registers
  task automatic wc(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] q;
    cmd(c);
    acc(1'b0, 1'b0, d, q);
  endtask
  task automatic rd(output logic [15:0] q);
    acc(1'b0, 1'b1, 16'h0000, q);
  endtask
  task automatic rc(input logic [7:0] c, output logic [15:0] q);
    cmd(c);
    rd(q);
  endtask
endmodule

// file: verilog/ucp_command_port.sv
// Module: command interpreter behind the 16-bit processor port
`timescale 1ns/100ps
module ucp_command_port (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        bus_cs_n,
  input  wire logic        bus_a0,
  input  wire logic        bus_rd_n,
  input  wire logic        bus_wr_n,
  input  wire logic [15:0] bus_data_in,
  output logic      [15:0] bus_data_out,
  output logic             bus_data_oe,
  input  wire logic [15:0] ep_full,
  input  wire logic [15:0] rx_len,
  input  wire logic [15:0] rx_word,
  output logic             rx_take,
  input  wire logic [7:0]  err_code_out,
  input  wire logic [7:0]  err_code_in,
  output logic             tx_valid,
  output logic      [15:0] tx_data,
  output logic      [3:0]  tx_ep,
  output logic             tx_last,
  output logic             tx_odd,
  input  wire logic        tx_ready,
  output logic      [15:0] stall_mask,
  output logic             ep_validate,
  output logic             ep_clear,
  output logic             status_ack,
  output logic      [3:0]  evt_ep,
  output logic             setup_ack,
  output logic             fill_overflow,
  output logic      [7:0]  usb_address_reg,
  output logic      [7:0]  operating_mode_reg,
  output logic      [15:0] hardware_setup_reg,
  output logic      [31:0] irq_mask_reg,
  output logic      [15:0] dma_setup_reg,
  output logic      [15:0] dma_byte_count_reg
);
  logic [1:0]               rst_s_q;
  logic                     rst_sync_n;
  logic [2:0]               cs_s_q, a0_s_q, rd_s_q, wr_s_q;
  logic [15:0]              din_s1_q, din_s2_q, din_s3_q;
  logic                     cmd_ev, dat_wr, dat_rd, wr_end, rd_end;
  ucp_pkg::ucp_state_t      state_q;
  logic [7:0]               cmd_q;
  logic [ucp_pkg::IDX_W-1:0] idx_q;
  logic [7:0]               cfg_q [16];
  logic [7:0]               code_sel;
  logic [ucp_pkg::IDX_W-1:0] idx_sel;
  logic [15:0]              rword;
  logic                     rtake;
  logic [15:0]              fill_left_q;
  logic                     fill_odd_q;
  logic                     push_valid_q;
  logic [ucp_pkg::TXF_W-1:0] push_data_q;
  logic                     fill_word;
  logic                     soft_rst;

  ucp_fifo_if #(.W(ucp_pkg::TXF_W)) txf ();

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);

  function automatic logic [15:0] words_of(input logic [15:0] n);
    logic [16:0] t;
    t = ({1'b0, n} + 17'h00001) >> 1;
    return t[15:0];
  endfunction

  function automatic logic [15:0] clip_len(input logic [15:0] n, input logic iso);
    logic [15:0] lim;
    lim = iso ? ucp_pkg::MAX_LEN_ISO : ucp_pkg::MAX_LEN_STD;
    return (n > lim) ? lim : n;
  endfunction

  function automatic ucp_pkg::ucp_state_t phase_of(input logic [7:0] c);
    ucp_pkg::ucp_state_t s;
    s = ucp_pkg::UCP_IDLE;
    case (c[7:4])
      ucp_pkg::GRP_FILL:   s = (c[3:0] != ucp_pkg::EP_CTRL_OUT) ? ucp_pkg::UCP_WDATA
                                                                : ucp_pkg::UCP_IDLE;
      ucp_pkg::GRP_DRAIN:  s = (c[3:0] != ucp_pkg::EP_CTRL_IN) ? ucp_pkg::UCP_RDATA
                                                               : ucp_pkg::UCP_IDLE;
      ucp_pkg::GRP_CFG_WR: s = ucp_pkg::UCP_WDATA;
      ucp_pkg::GRP_CFG_RD,
      ucp_pkg::GRP_STAT,
      ucp_pkg::GRP_IMAGE:  s = ucp_pkg::UCP_RDATA;
      default: begin
        case (c)
          ucp_pkg::CMD_ERR_OUT, ucp_pkg::CMD_ERR_IN, ucp_pkg::CMD_ADDR_RD,
          ucp_pkg::CMD_MODE_RD, ucp_pkg::CMD_HW_RD, ucp_pkg::CMD_IRQ_RD,
          ucp_pkg::CMD_DMAC_RD, ucp_pkg::CMD_DMAN_RD: s = ucp_pkg::UCP_RDATA;
          ucp_pkg::CMD_ADDR_WR, ucp_pkg::CMD_MODE_WR, ucp_pkg::CMD_HW_WR,
          ucp_pkg::CMD_IRQ_WR, ucp_pkg::CMD_DMAC_WR, ucp_pkg::CMD_DMAN_WR:
            s = ucp_pkg::UCP_WDATA;
          default: s = ucp_pkg::UCP_IDLE;
        endcase
      end
    endcase
    return s;
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s_q <= 2'h0;
    end else begin
      rst_s_q <= {rst_s_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_s_q[1];

  // Pins are asynchronous; third stage feeds edge detection, the select and A0 qualifiers and the data word
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cs_s_q   <= 3'h7;
      a0_s_q   <= 3'h0;
      rd_s_q   <= 3'h7;
      wr_s_q   <= 3'h7;
      din_s1_q <= 16'h0000;
      din_s2_q <= 16'h0000;
      din_s3_q <= 16'h0000;
    end else begin
      cs_s_q   <= {cs_s_q[1:0], bus_cs_n};
      a0_s_q   <= {a0_s_q[1:0], bus_a0};
      rd_s_q   <= {rd_s_q[1:0], bus_rd_n};
      wr_s_q   <= {wr_s_q[1:0], bus_wr_n};
      din_s1_q <= bus_data_in;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
    end
  end

  // Access acts at the strobe's trailing edge, when data has settled
  assign wr_end = wr_s_q[1] & ~wr_s_q[2];
  assign rd_end = rd_s_q[1] & ~rd_s_q[2];
  assign cmd_ev = wr_end & ~cs_s_q[2] & a0_s_q[2];
  assign dat_wr = wr_end & ~cs_s_q[2] & ~a0_s_q[2] & (state_q == ucp_pkg::UCP_WDATA);
  assign dat_rd = rd_end & ~cs_s_q[2] & ~a0_s_q[2] & (state_q == ucp_pkg::UCP_RDATA);
  assign soft_rst = cmd_ev & (din_s3_q[7:0] == ucp_pkg::CMD_DEV_RESET);

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= ucp_pkg::UCP_IDLE;
      cmd_q   <= 8'h00;
      idx_q   <= '0;
    end else if (cmd_ev) begin
      cmd_q   <= din_s3_q[7:0];
      state_q <= phase_of(din_s3_q[7:0]);
      idx_q   <= '0;
    end else if ((dat_wr | dat_rd) && idx_q != ucp_pkg::IDX_MAX) begin
      idx_q   <= idx_q + 1'b1;
    end
  end

  AST_CMD_LOW_BYTE: assert property (cmd_ev |=> cmd_q == $past(din_s3_q[7:0]))
    else $error("command code not taken from low byte");

  // Read word for the preload at command time or the advance at each read
  always_comb begin
    code_sel = cmd_ev ? din_s3_q[7:0] : cmd_q;
    // An advance fetches the word after the one just read out
    idx_sel  = cmd_ev ? '0
             : (idx_q == ucp_pkg::IDX_MAX) ? idx_q : idx_q + 1'b1;
    rword    = 16'h0000;
    rtake    = 1'b0;
    case (code_sel[7:4])
      ucp_pkg::GRP_DRAIN: begin
        if (idx_sel == '0) begin
          rword = rx_len;
        end else if ({6'h00, idx_sel} <= words_of(rx_len)) begin
          rword = rx_word;
          rtake = 1'b1;
        end
      end
      ucp_pkg::GRP_CFG_RD: begin
        rword = (idx_sel == '0) ? {8'h00, cfg_q[code_sel[3:0]]} : 16'h0000;
      end
      ucp_pkg::GRP_STAT,
      ucp_pkg::GRP_IMAGE: begin
        if (idx_sel == '0) begin
          rword = {14'h0000, stall_mask[code_sel[3:0]], ep_full[code_sel[3:0]]};
        end
      end
      default: begin
        if (idx_sel == '0) begin
          case (code_sel)
            ucp_pkg::CMD_ERR_OUT: rword = {8'h00, err_code_out};
            ucp_pkg::CMD_ERR_IN:  rword = {8'h00, err_code_in};
            ucp_pkg::CMD_ADDR_RD: rword = {8'h00, usb_address_reg};
            ucp_pkg::CMD_MODE_RD: rword = {8'h00, operating_mode_reg};
            ucp_pkg::CMD_HW_RD:   rword = hardware_setup_reg;
            ucp_pkg::CMD_IRQ_RD:  rword = irq_mask_reg[15:0];
            ucp_pkg::CMD_DMAC_RD: rword = dma_setup_reg;
            ucp_pkg::CMD_DMAN_RD: rword = dma_byte_count_reg;
            default:              rword = 16'h0000;
          endcase
        end else if (idx_sel == 10'h001 && code_sel == ucp_pkg::CMD_IRQ_RD) begin
          rword = irq_mask_reg[31:16];
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_data_out <= 16'h0000;
      bus_data_oe  <= 1'b0;
      rx_take      <= 1'b0;
    end else begin
      bus_data_oe  <= ~cs_s_q[1] & ~rd_s_q[1];
      rx_take      <= dat_rd & rtake;
      if (cmd_ev || dat_rd) begin
        bus_data_out <= rword;
      end
    end
  end

  AST_TAKE_ONLY_ON_READ: assert property (rx_take |-> $past(dat_rd))
    else $error("buffer word taken without a data read");

  // Endpoint setup words; reset also drops every endpoint back to disabled
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < 16; i++) begin
        cfg_q[i] <= ucp_pkg::RST_CFG;
      end
    end else if (soft_rst) begin
      for (int i = 0; i < 16; i++) begin
        cfg_q[i] <= ucp_pkg::RST_CFG;
      end
    end else if (dat_wr && cmd_q[7:4] == ucp_pkg::GRP_CFG_WR && idx_q == '0) begin
      cfg_q[cmd_q[3:0]] <= din_s3_q[7:0];
    end
  end

  sequence s_cfg_write;
    dat_wr && cmd_q[7:4] == ucp_pkg::GRP_CFG_WR && idx_q == '0;
  endsequence
  AST_CFG_WRITE: assert property (s_cfg_write |=>
                                  cfg_q[$past(cmd_q[3:0])] == $past(din_s3_q[7:0]))
    else $error("endpoint setup word not stored");

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      usb_address_reg    <= ucp_pkg::RST_ADDR;
      operating_mode_reg <= ucp_pkg::RST_MODE;
      hardware_setup_reg <= ucp_pkg::RST_HW;
      irq_mask_reg       <= ucp_pkg::RST_IRQ;
      dma_setup_reg      <= ucp_pkg::RST_DMAC;
      dma_byte_count_reg <= ucp_pkg::RST_DMAN;
    end else if (soft_rst) begin
      usb_address_reg    <= ucp_pkg::RST_ADDR;
      operating_mode_reg <= ucp_pkg::RST_MODE;
      hardware_setup_reg <= ucp_pkg::RST_HW;
      irq_mask_reg       <= ucp_pkg::RST_IRQ;
      dma_setup_reg      <= ucp_pkg::RST_DMAC;
      dma_byte_count_reg <= ucp_pkg::RST_DMAN;
    end else if (dat_wr && idx_q == '0) begin
      case (cmd_q)
        ucp_pkg::CMD_ADDR_WR: usb_address_reg    <= din_s3_q[7:0];
        ucp_pkg::CMD_MODE_WR: operating_mode_reg <= din_s3_q[7:0];
        ucp_pkg::CMD_HW_WR:   hardware_setup_reg <= din_s3_q;
        ucp_pkg::CMD_IRQ_WR:  irq_mask_reg[15:0] <= din_s3_q;
        ucp_pkg::CMD_DMAC_WR: dma_setup_reg      <= din_s3_q;
        ucp_pkg::CMD_DMAN_WR: dma_byte_count_reg <= din_s3_q;
        default: ;
      endcase
    end else if (dat_wr && idx_q == 10'h001 && cmd_q == ucp_pkg::CMD_IRQ_WR) begin
      irq_mask_reg[31:16] <= din_s3_q;
    end
  end

  AST_SOFT_RESET: assert property (soft_rst |=> usb_address_reg == ucp_pkg::RST_ADDR
                                   && irq_mask_reg == ucp_pkg::RST_IRQ
                                   && stall_mask == 16'h0000)
    else $error("device reset did not restore registers");

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stall_mask <= 16'h0000;
    end else if (soft_rst) begin
      stall_mask <= 16'h0000;
    end else if (cmd_ev && din_s3_q[7:4] == ucp_pkg::GRP_STALL) begin
      stall_mask[din_s3_q[3:0]] <= 1'b1;
    end else if (cmd_ev && din_s3_q[7:4] == ucp_pkg::GRP_UNSTALL) begin
      stall_mask[din_s3_q[3:0]] <= 1'b0;
    end
  end

  AST_STALL_AT_ONCE: assert property (cmd_ev && din_s3_q[7:4] == ucp_pkg::GRP_STALL
                                      |=> stall_mask[$past(din_s3_q[3:0])])
    else $error("stall command not applied next cycle");

  // Event pulses toward the endpoint engine, one cycle each
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ep_validate <= 1'b0;
      ep_clear    <= 1'b0;
      status_ack  <= 1'b0;
      setup_ack   <= 1'b0;
      evt_ep      <= 4'h0;
    end else begin
      ep_validate <= cmd_ev && din_s3_q[7:4] == ucp_pkg::GRP_VALID
                     && din_s3_q[3:0] != ucp_pkg::EP_CTRL_OUT;
      ep_clear    <= cmd_ev && din_s3_q[7:4] == ucp_pkg::GRP_CLEAR
                     && din_s3_q[3:0] != ucp_pkg::EP_CTRL_IN;
      // A plain state read lets the engine drop its event bits; a copy read does not
      status_ack  <= cmd_ev && din_s3_q[7:4] == ucp_pkg::GRP_STAT;
      setup_ack   <= cmd_ev && din_s3_q[7:0] == ucp_pkg::CMD_SETUP_ACK;
      if (cmd_ev) begin
        evt_ep <= din_s3_q[3:0];
      end
    end
  end

  AST_VALIDATE_60_IGNORED: assert property (cmd_ev && din_s3_q[7:4] == ucp_pkg::GRP_VALID
                                            && din_s3_q[3:0] == ucp_pkg::EP_CTRL_OUT
                                            |=> !ep_validate)
    else $error("illegal validate code acted on");
  AST_CLEAR_PULSE: assert property (cmd_ev && din_s3_q[7:4] == ucp_pkg::GRP_CLEAR
                                    && din_s3_q[3:0] != ucp_pkg::EP_CTRL_IN
                                    |=> ep_clear && evt_ep == $past(din_s3_q[3:0])
                                    ##1 !ep_clear)
    else $error("clear pulse wrong");
  AST_IMAGE_NO_ACK: assert property (cmd_ev && din_s3_q[7:4] == ucp_pkg::GRP_IMAGE
                                     |=> !status_ack && $stable(stall_mask))
    else $error("state copy read disturbed state");

  // IN buffer fill: first word is the length, then (N+1)/2 payload words
  assign fill_word = dat_wr && cmd_q[7:4] == ucp_pkg::GRP_FILL && idx_q != '0
                     && fill_left_q != 16'h0000;

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fill_left_q <= 16'h0000;
      fill_odd_q  <= 1'b0;
    end else if (soft_rst) begin
      fill_left_q <= 16'h0000;
    end else if (dat_wr && cmd_q[7:4] == ucp_pkg::GRP_FILL && idx_q == '0) begin
      fill_left_q <= words_of(clip_len(din_s3_q,
                     cfg_q[cmd_q[3:0]][ucp_pkg::CFG_ISO_BIT]));
      fill_odd_q  <= 1'(clip_len(din_s3_q, cfg_q[cmd_q[3:0]][ucp_pkg::CFG_ISO_BIT]) & 16'h0001);
    end else if (fill_word) begin
      fill_left_q <= fill_left_q - 16'h0001;
    end
  end

  // The bus cannot be stalled, so a word that meets a full FIFO is dropped
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      push_valid_q  <= 1'b0;
      push_data_q   <= '0;
      fill_overflow <= 1'b0;
    end else if (soft_rst) begin
      push_valid_q  <= 1'b0;
      fill_overflow <= 1'b0;
    end else if (fill_word && (!push_valid_q || txf.push_ready)) begin
      push_valid_q <= 1'b1;
      push_data_q  <= {fill_left_q == 16'h0001, fill_odd_q, cmd_q[3:0], din_s3_q};
    end else if (fill_word) begin
      fill_overflow <= 1'b1;
    end else if (txf.push_ready) begin
      push_valid_q <= 1'b0;
    end
  end

  AST_ODD_ON_LAST: assert property (push_valid_q && push_data_q[ucp_pkg::TXF_LAST]
                                    |-> push_data_q[ucp_pkg::TXF_ODD] == fill_odd_q)
    else $error("odd flag on last word wrong");

  assign txf.push_valid = push_valid_q;
  assign txf.push_data  = push_data_q;
  assign txf.pop_ready  = tx_ready;
  assign txf.flush      = soft_rst;
  assign tx_valid       = txf.pop_valid;
  assign tx_data        = txf.pop_data[15:0];
  assign tx_ep          = txf.pop_data[ucp_pkg::TXF_ODD-1:ucp_pkg::TXF_EP_LO];
  assign tx_last        = txf.pop_data[ucp_pkg::TXF_LAST];
  assign tx_odd         = txf.pop_data[ucp_pkg::TXF_ODD];

  ucp_fifo #(
    .W     (ucp_pkg::TXF_W),
    .DEPTH (ucp_pkg::TXF_DEPTH)
  ) u_txf (
    .core_clk   (core_clk),
    .rst_sync_n (rst_sync_n),
    .f          (txf)
  );
endmodule

// file: verilog/ucp_fifo.sv
// Module: small FIFO with registered output word
`timescale 1ns/100ps
module ucp_fifo #(
  parameter int unsigned W     = 22,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic core_clk,
  input  wire logic rst_sync_n,
  ucp_fifo_if.mem   f
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("ucp_fifo: DEPTH must be a power of two of at least 2");
  end
  if ($bits(f.push_data) != W) begin : g_bad_width
    $error("ucp_fifo: W does not match interface width");
  end

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          out_v_q;
  logic [W-1:0]  out_d_q;
  logic          push;
  logic          load;

  // Ready comes from the count alone so the source sees back-pressure early
  assign f.push_ready = (cnt_q < (AW+1)'(DEPTH));
  assign push         = f.push_valid & f.push_ready;
  assign load         = (cnt_q != '0) & (~out_v_q | f.pop_ready);
  assign f.pop_valid  = out_v_q;
  assign f.pop_data   = out_d_q;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wp_q] <= f.push_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (f.flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= push ? wp_q + 1'b1 : wp_q;
      rp_q  <= load ? rp_q + 1'b1 : rp_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_v_q <= 1'b0;
      out_d_q <= '0;
    end else if (f.flush) begin
      out_v_q <= 1'b0;
    end else if (load) begin
      out_v_q <= 1'b1;
      out_d_q <= mem_q[rp_q];
    end else if (f.pop_ready) begin
      out_v_q <= 1'b0;
    end
  end
endmodule
